/* File: cpuidr_regs.svh */
// Register offsets, field positions, reset values and timing counts
`ifndef CPUIDR_REGS_SVH
`define CPUIDR_REGS_SVH

// Word offsets on the bus (byte addresses)
`define CPUIDR_CTRL_OFS      8'h00
`define CPUIDR_STAT_OFS      8'h04
`define CPUIDR_SEL_OFS       8'h08
`define CPUIDR_EAX_OFS       8'h0c
`define CPUIDR_EBX_OFS       8'h10
`define CPUIDR_ECX_OFS       8'h14
`define CPUIDR_EDX_OFS       8'h18
`define CPUIDR_RESETID_OFS   8'h1c
`define CPUIDR_EFLAGS_OFS    8'h20
`define CPUIDR_SMIEN_OFS     8'h24
`define CPUIDR_NMIPORT_OFS   8'h28
`define CPUIDR_SRPORT_OFS    8'h2c
`define CPUIDR_SRREAD_OFS    8'h30
`define CPUIDR_REVID_OFS     8'h34

// Control register fields
`define CPUIDR_CTRL_GO_BIT   0
`define CPUIDR_CTRL_KBD_BIT  1
`define CPUIDR_CTRL_TF_BIT   2
`define CPUIDR_CTRL_WB_BIT   3
`define CPUIDR_CTRL_MUL_LO   4
`define CPUIDR_CTRL_MUL_HI   5

// Status register fields
`define CPUIDR_STAT_BUSY_BIT 0
`define CPUIDR_STAT_SMIP_BIT 1
`define CPUIDR_STAT_NMIP_BIT 2
`define CPUIDR_STAT_SMIO_BIT 3
`define CPUIDR_STAT_NMIO_BIT 4
`define CPUIDR_STAT_SR_BIT   5

// Enable bits and flag positions
`define CPUIDR_SMIEN_BIT     0
`define CPUIDR_NMIMASK_BIT   7
`define CPUIDR_SRPORT_BIT    0
`define CPUIDR_IDFLAG_BIT    21

// Reset values
`define CPUIDR_SMIEN_RST     1'b0
`define CPUIDR_NMIMASK_RST   1'b1
`define CPUIDR_IDFLAG_RST    1'b0

// Identify result constants
`define CPUIDR_MAX_SEL       32'h0000_0001
`define CPUIDR_NULL_WORD     32'h0000_0000
`define CPUIDR_NO_FPU_BIT    0

// Execution times in core clocks
`define CPUIDR_CLK_SEL0      6'd41
`define CPUIDR_CLK_SEL1      6'd14
`define CPUIDR_CLK_SELN      6'd9

`endif

/* File: cpuidr_pkg.sv */
// Types shared by the identify and soft reset block
package cpuidr_pkg;
    typedef enum logic [2:0] {
        CPUIDR_IDLE = 3'b001,
        CPUIDR_EXEC = 3'b010,
        CPUIDR_DONE = 3'b100
    } cpuidr_state_e;

    typedef logic [31:0] cpuidr_word_t;
endpackage

/* File: cpuidr_edge_req.sv */
// Edge detecting request latch for one core interrupt input
`timescale 1ns/1ns
module cpuidr_edge_req (
    // Clock and reset
    input  wire logic clk_i,
    input  wire logic rst_i,
    // Control
    input  wire logic soft_rst_i,
    input  wire logic req_i,
    input  wire logic ack_i,
    // Status
    output logic      pend_o
);
    logic req_d_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            req_d_r <= 1'b0;
        end else begin
            req_d_r <= req_i;
        end
    end

    // Soft reset beats an arriving edge; the line stays high afterwards, so
    // no new edge appears until software drops the gate and reopens it.
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst_i) begin
            pend_o <= 1'b0;                      // [RULE2] [RULE4]
        end else if (req_i && !req_d_r) begin
            pend_o <= 1'b1;                      // [RULE1]
        end else if (ack_i) begin
            pend_o <= 1'b0;
        end
    end
endmodule // cpuidr_edge_req

/* File: cpuidr_core.sv */
// Processor identify engine and soft reset interrupt handling
//
// Summary of operation
// (RULE1) Core sees NMI and SMI only on edges
// (RULE2) Soft reset discards latched NMI, SMI requests
// (RULE3) Sources hold request until source is cleared
// (RULE4) Held request after soft reset gives no edge
// (RULE5) Boot code toggles enables to re-create edges
// (RULE6) SMI enable bit gates SMI to core
// (RULE7) NMI mask bit holds NMI inactive
// (RULE8) Port bit, port read, keyboard, fault: soft reset
// (RULE9) Identification value left in DX after reset
// (RULE10) Read-only revision register at index FFh; here it sits at bus offset 34h
// (RULE11) Writable identify support flag, bit 21
// (RULE12) Flag cleared by power-on and soft reset
// (RULE13) Software installs invalid opcode handler first
// (RULE14) Identify takes 41, 14 or 9 clocks
// (RULE15) Selector 0 vendor, selector 1 description
// (RULE16) Software rejects mismatched vendor string
// (RULE17) Description: write-back cache, no FPU
// (RULE18) Results ignore cache mode and clock multiplier
// (RULE19) Selector 0 EAX is highest selector, 1
// (RULE20) Selector 1 EAX equals reset DX value
// (RULE21) Selector 1 EDX bit 0 is zero
// (RULE22) Selector above 1 returns all zeros
`timescale 1ns/1ns
`include "cpuidr_regs.svh"
module cpuidr_core #(
    // Identity words, arbitrary neutral values
    parameter logic [31:0] VENDOR_B  = 32'h6e65_7574,
    parameter logic [31:0] VENDOR_D  = 32'h6c61_7274,
    parameter logic [31:0] VENDOR_C  = 32'h3030_7055,
    parameter logic [31:0] DEVICE_ID = 32'h0000_04a4,  // arbitrary
    parameter logic [31:0] FEATURES  = 32'h0000_0100,  // arbitrary; bit0=0
    parameter logic [7:0]  REV_ID    = 8'h01           // arbitrary
) (
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Wishbone slave
    input  wire logic        cyc_i,
    input  wire logic        stb_i,
    input  wire logic        we_i,
    input  wire logic [7:0]  adr_i,
    input  wire logic [3:0]  sel_i,
    input  wire logic [31:0] dat_i,
    output logic      [31:0] dat_o,
    output logic             ack_o,
    // Interrupt sources from power management logic (pins)
    input  wire logic        smi_src_i,
    input  wire logic        nmi_src_i,
    // Core side
    output logic             smi_core_o,
    output logic             nmi_core_o,
    output logic             soft_cpu_reset_o,
    output logic             smi_pend_o,
    output logic             nmi_pend_o
);
    // ------------------------------------------------------------------
    // Input synchronisers
    // ------------------------------------------------------------------
    logic smi_m_r, smi_s_r, nmi_m_r, nmi_s_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smi_m_r <= 1'b0;
            smi_s_r <= 1'b0;
            nmi_m_r <= 1'b0;
            nmi_s_r <= 1'b0;
        end else begin
            smi_m_r <= smi_src_i;
            smi_s_r <= smi_m_r;
            nmi_m_r <= nmi_src_i;
            nmi_s_r <= nmi_m_r;
        end
    end

    // ------------------------------------------------------------------
    // Bus decode
    // ------------------------------------------------------------------
    logic req, wr, rd;
    assign req = cyc_i && stb_i && !ack_o;
    assign wr  = req && we_i;
    assign rd  = req && !we_i;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_o <= 1'b0;
        end else begin
            ack_o <= req;
        end
    end

    // ------------------------------------------------------------------
    // Software controls
    // ------------------------------------------------------------------
    logic smi_en_r, nmi_mask_r, id_flag_r, srport_r;
    logic wb_mode_r;
    logic [1:0] clk_mul_r;
    logic [31:0] sel_r;
    logic go, kbd_rst, tfault, port_sr, read_sr, soft_rst;

    assign go      = wr && adr_i == `CPUIDR_CTRL_OFS && sel_i[0]
                     && dat_i[`CPUIDR_CTRL_GO_BIT];
    assign kbd_rst = wr && adr_i == `CPUIDR_CTRL_OFS && sel_i[0]
                     && dat_i[`CPUIDR_CTRL_KBD_BIT];
    assign tfault  = wr && adr_i == `CPUIDR_CTRL_OFS && sel_i[0]
                     && dat_i[`CPUIDR_CTRL_TF_BIT];
    assign port_sr = wr && adr_i == `CPUIDR_SRPORT_OFS && sel_i[0]
                     && dat_i[`CPUIDR_SRPORT_BIT] && !srport_r;
    assign read_sr = rd && adr_i == `CPUIDR_SRREAD_OFS;
    // Any one cause is enough
    assign soft_rst = port_sr || read_sr || kbd_rst || tfault;  // [RULE8]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            soft_cpu_reset_o <= 1'b0;
        end else begin
            soft_cpu_reset_o <= soft_rst;                       // [RULE8]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            srport_r <= 1'b0;
        end else if (wr && adr_i == `CPUIDR_SRPORT_OFS && sel_i[0]) begin
            srport_r <= dat_i[`CPUIDR_SRPORT_BIT];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smi_en_r <= `CPUIDR_SMIEN_RST;
        end else if (wr && adr_i == `CPUIDR_SMIEN_OFS && sel_i[0]) begin
            smi_en_r <= dat_i[`CPUIDR_SMIEN_BIT];               // [RULE6]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            nmi_mask_r <= `CPUIDR_NMIMASK_RST;
        end else if (wr && adr_i == `CPUIDR_NMIPORT_OFS && sel_i[0]) begin
            nmi_mask_r <= dat_i[`CPUIDR_NMIMASK_BIT];           // [RULE7]
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            id_flag_r <= `CPUIDR_IDFLAG_RST;                    // [RULE12]
        end else if (wr && adr_i == `CPUIDR_EFLAGS_OFS && sel_i[2]) begin
            id_flag_r <= dat_i[`CPUIDR_IDFLAG_BIT];             // [RULE11]
        end
    end

    // Cache mode and multiplier are stored but never reach the results
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_mode_r <= 1'b1;
            clk_mul_r <= 2'b01;
        end else if (wr && adr_i == `CPUIDR_CTRL_OFS && sel_i[0]) begin
            wb_mode_r <= dat_i[`CPUIDR_CTRL_WB_BIT];            // [RULE18]
            clk_mul_r <= dat_i[`CPUIDR_CTRL_MUL_HI:`CPUIDR_CTRL_MUL_LO];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sel_r <= `CPUIDR_NULL_WORD;
        end else if (wr && adr_i == `CPUIDR_SEL_OFS) begin
            for (int b = 0; b < 4; b++) begin
                if (sel_i[b]) begin
                    sel_r[b*8 +: 8] <= dat_i[b*8 +: 8];
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // Interrupt delivery to the core
    // ------------------------------------------------------------------
    logic smi_gated, nmi_gated;
    // Sources hold their level until cleared; gating forces it low
    assign smi_gated = smi_s_r && smi_en_r;                     // [RULE6]
    assign nmi_gated = nmi_s_r && !nmi_mask_r;                  // [RULE7]

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            smi_core_o <= 1'b0;
            nmi_core_o <= 1'b0;
        end else begin
            smi_core_o <= smi_gated;                            // [RULE3]
            nmi_core_o <= nmi_gated;                            // [RULE3]
        end
    end

    // Ack from core servicing is modelled by a status write of ones
    logic smi_ack, nmi_ack;
    assign smi_ack = wr && adr_i == `CPUIDR_STAT_OFS && sel_i[0]
                     && dat_i[`CPUIDR_STAT_SMIP_BIT];
    assign nmi_ack = wr && adr_i == `CPUIDR_STAT_OFS && sel_i[0]
                     && dat_i[`CPUIDR_STAT_NMIP_BIT];

    cpuidr_edge_req u_smi_req (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .soft_rst_i (soft_rst),
        .req_i      (smi_core_o),
        .ack_i      (smi_ack),
        .pend_o     (smi_pend_o)
    );

    cpuidr_edge_req u_nmi_req (
        .clk_i      (clk_i),
        .rst_i      (rst_i),
        .soft_rst_i (soft_rst),
        .req_i      (nmi_core_o),
        .ack_i      (nmi_ack),
        .pend_o     (nmi_pend_o)
    );

    // ------------------------------------------------------------------
    // Identify engine
    // ------------------------------------------------------------------
    cpuidr_pkg::cpuidr_state_e state_r;
    logic [5:0]  cnt_r;
    logic [31:0] eax_r, ebx_r, ecx_r, edx_r;
    logic [5:0]  len;

    always_comb begin
        if (sel_r == 32'h0000_0000) begin
            len = `CPUIDR_CLK_SEL0;                             // [RULE14]
        end else if (sel_r == 32'h0000_0001) begin
            len = `CPUIDR_CLK_SEL1;                             // [RULE14]
        end else begin
            len = `CPUIDR_CLK_SELN;                             // [RULE14]
        end
    end

    // Count leaves one clock for DONE, so busy lasts exactly len clocks
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            state_r <= cpuidr_pkg::CPUIDR_IDLE;
            cnt_r   <= 6'h00;
        end else begin
            unique case (state_r)
                cpuidr_pkg::CPUIDR_IDLE: begin
                    if (go) begin
                        state_r <= cpuidr_pkg::CPUIDR_EXEC;
                        cnt_r   <= len - 6'h01;
                    end
                end
                cpuidr_pkg::CPUIDR_EXEC: begin
                    if (cnt_r == 6'h01) begin
                        state_r <= cpuidr_pkg::CPUIDR_DONE;
                    end
                    cnt_r <= cnt_r - 6'h01;
                end
                cpuidr_pkg::CPUIDR_DONE: begin
                    state_r <= cpuidr_pkg::CPUIDR_IDLE;
                end
                default: begin
                    state_r <= cpuidr_pkg::CPUIDR_IDLE;
                end
            endcase
        end
    end

    // Results come only from constants, never from mode bits
    always_ff @(posedge clk_i) begin
        if (rst_i || soft_rst) begin
            eax_r <= `CPUIDR_NULL_WORD;
            ebx_r <= `CPUIDR_NULL_WORD;
            ecx_r <= `CPUIDR_NULL_WORD;
            edx_r <= DEVICE_ID;                                 // [RULE9]
        end else if (state_r == cpuidr_pkg::CPUIDR_DONE) begin
            if (sel_r == 32'h0000_0000) begin
                eax_r <= `CPUIDR_MAX_SEL;                       // [RULE19]
                ebx_r <= VENDOR_B;                              // [RULE15]
                edx_r <= VENDOR_D;
                ecx_r <= VENDOR_C;
            end else if (sel_r == 32'h0000_0001) begin
                eax_r <= DEVICE_ID;                             // [RULE20]
                ebx_r <= `CPUIDR_NULL_WORD;
                ecx_r <= `CPUIDR_NULL_WORD;
                // Write-back cache is in DEVICE_ID; no FPU here
                edx_r <= FEATURES                               // [RULE17]
                         & ~(32'h1 << `CPUIDR_NO_FPU_BIT);      // [RULE21]
            end else begin
                eax_r <= `CPUIDR_NULL_WORD;                     // [RULE22]
                ebx_r <= `CPUIDR_NULL_WORD;
                ecx_r <= `CPUIDR_NULL_WORD;
                edx_r <= `CPUIDR_NULL_WORD;
            end
        end
    end

    // ------------------------------------------------------------------
    // Read data
    // ------------------------------------------------------------------
    logic [31:0] rdata;
    logic        sr_seen_r;

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            sr_seen_r <= 1'b0;
        end else if (soft_rst) begin
            sr_seen_r <= 1'b1;
        end else if (wr && adr_i == `CPUIDR_STAT_OFS && sel_i[0]
                     && dat_i[`CPUIDR_STAT_SR_BIT]) begin
            sr_seen_r <= 1'b0;
        end
    end

    always_comb begin
        rdata = 32'h0000_0000;
        unique case (adr_i)
            `CPUIDR_CTRL_OFS: begin
                rdata[`CPUIDR_CTRL_WB_BIT] = wb_mode_r;
                rdata[`CPUIDR_CTRL_MUL_HI:`CPUIDR_CTRL_MUL_LO] = clk_mul_r;
            end
            `CPUIDR_STAT_OFS: begin
                rdata[`CPUIDR_STAT_BUSY_BIT] =
                    state_r != cpuidr_pkg::CPUIDR_IDLE;
                rdata[`CPUIDR_STAT_SMIP_BIT] = smi_pend_o;
                rdata[`CPUIDR_STAT_NMIP_BIT] = nmi_pend_o;
                rdata[`CPUIDR_STAT_SMIO_BIT] = smi_core_o;
                rdata[`CPUIDR_STAT_NMIO_BIT] = nmi_core_o;
                rdata[`CPUIDR_STAT_SR_BIT]   = sr_seen_r;
            end
            `CPUIDR_SEL_OFS:      rdata = sel_r;
            `CPUIDR_EAX_OFS:      rdata = eax_r;
            `CPUIDR_EBX_OFS:      rdata = ebx_r;
            `CPUIDR_ECX_OFS:      rdata = ecx_r;
            `CPUIDR_EDX_OFS:      rdata = edx_r;
            `CPUIDR_RESETID_OFS:  rdata = DEVICE_ID;
            `CPUIDR_EFLAGS_OFS:   rdata[`CPUIDR_IDFLAG_BIT] = id_flag_r;
            `CPUIDR_SMIEN_OFS:    rdata[`CPUIDR_SMIEN_BIT] = smi_en_r;
            `CPUIDR_NMIPORT_OFS:  rdata[`CPUIDR_NMIMASK_BIT] = nmi_mask_r;
            `CPUIDR_SRPORT_OFS:   rdata[`CPUIDR_SRPORT_BIT] = srport_r;
            `CPUIDR_REVID_OFS:    rdata[7:0] = REV_ID;          // [RULE10]
            default:              rdata = 32'h0000_0000;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            dat_o <= 32'h0000_0000;
        end else if (rd) begin
            dat_o <= rdata;
        end
    end
endmodule // cpuidr_core

/* File: cpuidr_core_checker.sv */
// Port-level checks for the identify and soft reset block
`timescale 1ns/1ns
`include "cpuidr_regs.svh"
module cpuidr_core_checker (
    // Clock and reset
    input wire logic       clk_i,
    input wire logic       rst_i,
    // Bus
    input wire logic       cyc_i,
    input wire logic       stb_i,
    input wire logic       we_i,
    input wire logic [7:0] adr_i,
    input wire logic       ack_o,
    // Interrupt and reset side
    input wire logic       smi_src_i,
    input wire logic       nmi_src_i,
    input wire logic       smi_core_o,
    input wire logic       nmi_core_o,
    input wire logic       soft_cpu_reset_o,
    input wire logic       smi_pend_o,
    input wire logic       nmi_pend_o
);
    // ------------------------------------------------------------------
    // Properties
    // ------------------------------------------------------------------
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    AST_ACK_NEXT: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
        else $error("ack missing one cycle after request");
    AST_ACK_ONCE: assert property (ack_o |=> !ack_o)
        else $error("ack held longer than one cycle");
    AST_SMI_GATE: assert property (
        smi_core_o |-> $past(smi_src_i, 3))
        else $error("smi to core without a source request");
    AST_NMI_GATE: assert property (
        nmi_core_o |-> $past(nmi_src_i, 3))
        else $error("nmi to core without a source request");
    AST_SMI_EDGE: assert property ($rose(smi_pend_o) |->
        $past(smi_core_o) && !$past(smi_core_o, 2))
        else $error("smi latched without a rising edge");
    AST_NMI_EDGE: assert property ($rose(nmi_pend_o) |->
        $past(nmi_core_o) && !$past(nmi_core_o, 2))
        else $error("nmi latched without a rising edge");
    AST_SR_CLEAR: assert property (soft_cpu_reset_o |->
        !smi_pend_o && !nmi_pend_o)
        else $error("latched request survives soft reset");
    AST_HELD_QUIET: assert property (smi_core_o && !smi_pend_o ##1
        smi_core_o && !smi_pend_o |=> !smi_pend_o)
        else $error("held smi latched again without an edge");
    AST_SR_READ: assert property (
        cyc_i && stb_i && !we_i && !ack_o &&
        adr_i == `CPUIDR_SRREAD_OFS |-> ##[1:3] soft_cpu_reset_o)
        else $error("reset port read gave no soft reset");
    AST_SR_PULSE: assert property (soft_cpu_reset_o |=> !soft_cpu_reset_o)
        else $error("soft reset pulse longer than one cycle");
endmodule // cpuidr_core_checker

bind cpuidr_core cpuidr_core_checker chk_u (
    .clk_i            (clk_i),
    .rst_i            (rst_i),
    .cyc_i            (cyc_i),
    .stb_i            (stb_i),
    .we_i             (we_i),
    .adr_i            (adr_i),
    .ack_o            (ack_o),
    .smi_src_i        (smi_src_i),
    .nmi_src_i        (nmi_src_i),
    .smi_core_o       (smi_core_o),
    .nmi_core_o       (nmi_core_o),
    .soft_cpu_reset_o (soft_cpu_reset_o),
    .smi_pend_o       (smi_pend_o),
    .nmi_pend_o       (nmi_pend_o)
);

/* File: cpuidr_core_bench.sv */
// Self-checking bench for the identify and soft reset block
`timescale 1ns/1ns
`include "cpuidr_regs.svh"
module cpuidr_core_bench;
    // Identity values, all arbitrary
    localparam logic [31:0] VB   = 32'h1111_2222;
    localparam logic [31:0] VD   = 32'h3333_4444;
    localparam logic [31:0] VC   = 32'h5555_6666;
    localparam logic [31:0] DID  = 32'h0000_0a5c;
    localparam logic [31:0] FEAT = 32'h0000_0081; // Bit 0 set on purpose
    localparam logic [7:0]  REV  = 8'h3c;
    localparam logic [31:0] IDF  = 32'h0020_0000;
    localparam logic [31:0] SELS [4] = '{32'h0, 32'h1, 32'h2, 32'hffff_ffff};
    localparam int          CLKS [4] = '{41, 14, 9, 9};

    logic        clk_i = 1'b0;
    logic        rst_i = 1'b1;
    logic        cyc_i = 1'b0;
    logic        stb_i = 1'b0;
    logic        we_i  = 1'b0;
    logic [7:0]  adr_i = 8'h00;
    logic [3:0]  sel_i = 4'hf;
    logic [31:0] dat_i = 32'h0;
    logic [31:0] dat_o;
    logic        ack_o;
    logic        smi_src_i = 1'b0;
    logic        nmi_src_i = 1'b0;
    logic        smi_core_o;
    logic        nmi_core_o;
    logic        soft_cpu_reset_o;
    logic        smi_pend_o;
    logic        nmi_pend_o;
    int          errors = 0;
    int          samples_checked = 0;
    int          sr_cnt = 0;

    cpuidr_core #(.VENDOR_B(VB), .VENDOR_D(VD), .VENDOR_C(VC),
        .DEVICE_ID(DID), .FEATURES(FEAT), .REV_ID(REV)) dut_u (
        .clk_i(clk_i), .rst_i(rst_i), .cyc_i(cyc_i), .stb_i(stb_i),
        .we_i(we_i), .adr_i(adr_i), .sel_i(sel_i), .dat_i(dat_i),
        .dat_o(dat_o), .ack_o(ack_o), .smi_src_i(smi_src_i),
        .nmi_src_i(nmi_src_i), .smi_core_o(smi_core_o),
        .nmi_core_o(nmi_core_o), .soft_cpu_reset_o(soft_cpu_reset_o),
        .smi_pend_o(smi_pend_o), .nmi_pend_o(nmi_pend_o));

    always #50 clk_i = ~clk_i;

    always @(posedge clk_i) begin
        if (soft_cpu_reset_o === 1'b1) sr_cnt++;
    end

    // ------------------------------------------------------------------
    // Bus and compare tasks
    // ------------------------------------------------------------------
    task automatic chk(input string nm, input logic [31:0] e,
                       input logic [31:0] g);
        samples_checked++;
        if (g !== e) begin
            errors++;
            $display("BAD %s expected %h seen %h", nm, e, g);
        end
    endtask

    // Holds the request until ack is sampled, then drops it for a cycle
    task automatic wb(input logic w, input logic [7:0] a,
                      input logic [31:0] d, output logic [31:0] q);
        cyc_i <= 1'b1;
        stb_i <= 1'b1;
        we_i  <= w;
        adr_i <= a;
        dat_i <= d;
        do @(posedge clk_i); while (ack_o !== 1'b1);
        q = dat_o;
        cyc_i <= 1'b0;
        stb_i <= 1'b0;
        @(posedge clk_i);
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] q;
        wb(1'b1, a, d, q);
    endtask

    task automatic rdc(input string nm, input logic [7:0] a,
                       input logic [31:0] e, input logic [31:0] m);
        logic [31:0] q;
        wb(1'b0, a, 32'h0, q);
        chk(nm, e & m, q & m);
    endtask

    // Busy is probed in its last clock, then idle on the next status read
    task automatic ident(input logic [31:0] s, input int n,
                         input logic [31:0] m);
        logic [31:0] e [4];
        e = '{32'h0, 32'h0, 32'h0, 32'h0};
        if (s == 32'h0) e = '{32'h0000_0001, VB, VC, VD};
        else if (s == 32'h1) e = '{DID, 32'h0, 32'h0, FEAT & ~32'h1};
        wr(`CPUIDR_SEL_OFS, s);
        wr(`CPUIDR_CTRL_OFS, m | 32'h1);
        repeat (n - 3) @(posedge clk_i);
        rdc("busy", `CPUIDR_STAT_OFS, 32'h1, 32'h1);
        rdc("idle", `CPUIDR_STAT_OFS, 32'h0, 32'h1);
        for (int r = 0; r < 4; r++) begin
            rdc("res", 8'(12 + 4 * r), e[r], '1);
        end
    endtask

    task automatic end_sim;
        $display("checks %0d errors %0d", samples_checked, errors);
        if (errors == 0 && samples_checked > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask

    initial begin
        repeat (6000) @(posedge clk_i);
        errors++;
        end_sim;
    end

    // ------------------------------------------------------------------
    // Test sequence
    // ------------------------------------------------------------------
    initial begin
        logic [31:0] q;
        int          n;
        repeat (6) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        rdc("id_flag", `CPUIDR_EFLAGS_OFS, 32'h0, IDF);
        rdc("smi_en", `CPUIDR_SMIEN_OFS, 32'h0, 32'h1);
        rdc("nmi_mask", `CPUIDR_NMIPORT_OFS, 32'h80, 32'h80);
        rdc("reset_id", `CPUIDR_RESETID_OFS, DID, '1);
        rdc("reset_edx", `CPUIDR_EDX_OFS, DID, '1);
        wr(`CPUIDR_REVID_OFS, 32'h0000_00ff);
        rdc("rev_id", `CPUIDR_REVID_OFS, {24'h0, REV}, 32'hff);
        rdc("unmapped", 8'h3c, 32'h0, '1);
        wr(`CPUIDR_EFLAGS_OFS, IDF);
        rdc("id_flag", `CPUIDR_EFLAGS_OFS, IDF, IDF);
        for (int i = 0; i < 8; i++) begin
            ident(SELS[i % 4], CLKS[i % 4], 32'(i) << 3);
        end
        smi_src_i <= 1'b1;
        repeat (8) @(posedge clk_i);
        chk("smi_core", 32'h0, {31'h0, smi_core_o});
        wr(`CPUIDR_SMIEN_OFS, 32'h1);
        repeat (5) @(posedge clk_i);
        chk("smi_core", 32'h1, {31'h0, smi_core_o});
        chk("smi_pend", 32'h1, {31'h0, smi_pend_o});
        wr(`CPUIDR_STAT_OFS, 32'h2);
        repeat (6) @(posedge clk_i);
        chk("smi_pend", 32'h0, {31'h0, smi_pend_o});
        wr(`CPUIDR_SMIEN_OFS, 32'h0);
        wr(`CPUIDR_SMIEN_OFS, 32'h1);
        repeat (5) @(posedge clk_i);
        chk("smi_pend", 32'h1, {31'h0, smi_pend_o});
        wb(1'b0, `CPUIDR_SRREAD_OFS, 32'h0, q);
        repeat (6) @(posedge clk_i);
        chk("smi_pend", 32'h0, {31'h0, smi_pend_o});
        chk("smi_core", 32'h1, {31'h0, smi_core_o});
        rdc("sr_seen", `CPUIDR_STAT_OFS, 32'h20, 32'h20);
        smi_src_i <= 1'b0;
        repeat (6) @(posedge clk_i);
        chk("smi_core", 32'h0, {31'h0, smi_core_o});
        // Each soft reset cause in turn, with a held NMI pending
        nmi_src_i <= 1'b1;
        for (int i = 0; i < 4; i++) begin
            wr(`CPUIDR_EFLAGS_OFS, IDF);
            wr(`CPUIDR_NMIPORT_OFS, 32'h80);
            wr(`CPUIDR_NMIPORT_OFS, 32'h0);
            repeat (5) @(posedge clk_i);
            chk("nmi_pend", 32'h1, {31'h0, nmi_pend_o});
            n = sr_cnt;
            case (i)
                0: wb(1'b0, `CPUIDR_SRREAD_OFS, 32'h0, q);
                1: wr(`CPUIDR_SRPORT_OFS, 32'h1);
                default: wr(`CPUIDR_CTRL_OFS, 32'h1 << (i - 1));
            endcase
            repeat (6) @(posedge clk_i);
            chk("sr_count", 32'(n + 1), 32'(sr_cnt));
            chk("nmi_pend", 32'h0, {31'h0, nmi_pend_o});
            chk("nmi_core", 32'h1, {31'h0, nmi_core_o});
            rdc("id_flag", `CPUIDR_EFLAGS_OFS, 32'h0, IDF);
        end
        rdc("reset_id", `CPUIDR_RESETID_OFS, DID, '1);
        rdc("sr_edx", `CPUIDR_EDX_OFS, DID, '1);
        end_sim;
    end
endmodule // cpuidr_core_bench
